// [hdl/dacr_regs.svh]
// Register offsets, field positions, reset values and timing counts.
// Assumes a word-indexed register port; offsets are word indices.
`ifndef DACR_REGS_SVH
`define DACR_REGS_SVH
`define DACR_ADDR_W        4
`define DACR_OFS_PACING    4'h1
`define DACR_OFS_EVENTS    4'h2
`define DACR_OFS_TRIM      4'h4
`define DACR_OFS_REFCTL    4'h5
`define DACR_BIT_FIN_MASK  16
`define DACR_BIT_STV_MASK  17
`define DACR_BIT_STV_STAT  3
`define DACR_BIT_LOW_FLAG  2
`define DACR_BIT_STV_FLAG  1
`define DACR_BIT_FIN_FLAG  0
`define DACR_BIT_COMP_POLE 5
`define DACR_BIT_REFERENCE_POWER_UP    4
`define DACR_BIT_REF_OUTEN 3
`define DACR_BIT_QUICK_PD  0
`define DACR_RST_WORD      32'h0000_0000
`define DACR_CLK_KHZ       25000
`define DACR_TICK_KHZ      2400
`define DACR_TICK_ADD      16'h0002
`endif

// [hdl/dacr_pkg.sv]
// Types shared by the reference and pacing logic.
// Assumes nothing of its surroundings.
package dacr_pkg;
	typedef enum logic [1:0] {
		MODE_FREE   = 2'b00,
		MODE_ONCE   = 2'b01,
		MODE_RSVD   = 2'b10,
		MODE_REPEAT = 2'b11
	} dacr_mode_t;
	typedef enum logic [1:0] {
		REF_1V024 = 2'b00,
		REF_1V5   = 2'b01,
		REF_2V048 = 2'b10,
		REF_2V5   = 2'b11
	} dacr_ref_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_DONE = 2'b10
	} dacr_state_t;
endpackage

// [hdl/dacr_tick.sv]
// Fractional divider making the 2.4 MHz time base as a one-cycle enable.
// Assumes a free-running clock at the rate given in the header.
`timescale 1ns/1ps
`include "dacr_regs.svh"
module dacr_tick #(
	parameter int CLK_KHZ  = `DACR_CLK_KHZ,
	parameter int TICK_KHZ = `DACR_TICK_KHZ
) (
	input  wire logic mclk_i,  // Clock
	input  wire logic rst_i,   // Sync reset
	output logic      tick_o   // 2.4 MHz enable
);
	localparam logic [15:0] INC = 16'(TICK_KHZ);
	localparam logic [15:0] MOD = 16'(CLK_KHZ);
	logic [15:0] acc_ff;
	logic [16:0] sum;
	assign sum = {1'b0, acc_ff} + {1'b0, INC};
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			acc_ff <= 16'h0000;
			tick_o <= 1'b0;
		end else if (sum >= {1'b0, MOD}) begin
			acc_ff <= 16'(sum - {1'b0, MOD});
			tick_o <= 1'b1;
		end else begin
			acc_ff <= sum[15:0];
			tick_o <= 1'b0;
		end
	end
endmodule

// [hdl/dacr_ctrl.sv]
// Pacing counter, point count, event flags and reference control.
// Assumes FIFO level, mode and interpolation come from logic on mclk_i.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "dacr_regs.svh"
module dacr_ctrl (
	input  wire logic        mclk_i,          // Clock 25 MHz
	input  wire logic        rst_i,           // Sync reset, high
	input  wire logic [3:0]  addr_i,          // Word index
	input  wire logic [31:0] wdata_i,         // Write data
	input  wire logic        wr_i,            // Write strobe
	input  wire logic        rd_i,            // Read strobe
	output logic      [31:0] rdata_o,         // Read data, next cycle
	input  wire logic [1:0]  output_sequencing_select_i, // Mode
	input  wire logic [3:0]  interp_i,        // Interpolation code
	input  wire logic [3:0]  low_level_threshold_i, // Almost-empty level
	input  wire logic [5:0]  fifo_level_i,    // FIFO fill level
	input  wire logic        fifo_empty_i,    // FIFO empty
	input  wire logic [15:0] trim_i,          // Trim value
	input  wire logic [1:0]  gain_i,          // Reference gain
	output logic             sample_o,        // Pop one sample
	output logic             irq_o,           // Interrupt level
	output logic [1:0]       ref_sel_o,       // Reference level
	output logic             reference_power_up_o, // Ref power
	output logic             ref_outen_o,     // Internal ref output
	output logic             reference_comp_pole_o, // Comp pole
	output logic             reference_quick_shutdown_o // Fast pd
);
	logic [15:0] point_cnt_ff;
	logic [15:0] interval_ff;
	logic        stv_mask_ff;
	logic        fin_mask_ff;
	logic        stv_stat_ff;
	logic        low_flag_ff;
	logic        stv_flag_ff;
	logic        fin_flag_ff;
	logic [1:0]  ref_sel_ff;
	logic [5:0]  ref_bits_ff;
	logic        tick;
	logic [16:0] wait_ff;
	logic [31:0] left_ff;
	dacr_pkg::dacr_state_t state_ff;
	logic        under_ev;
	logic        low_ev;
	logic        fin_ev;
	logic        low_prev_ff;
	logic        counted;
	logic        fire;
	logic        w_pace;
	logic        w_evt;
	logic        w_ref;

	function automatic logic [31:0] total_points(input logic [15:0] n,
		input logic [3:0] m);
		logic [2:0] sh;
		sh = (m > 4'h3) ? 3'h0 : m[2:0];
		total_points = (({16'h0000, n} - 32'h1) << sh) + 32'h1;
	endfunction

	dacr_tick u_tick (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.tick_o (tick)
	);

	assign counted = (output_sequencing_select_i ==
		dacr_pkg::MODE_ONCE) || (output_sequencing_select_i ==
		dacr_pkg::MODE_REPEAT);
	assign w_pace = wr_i && (addr_i == `DACR_OFS_PACING);
	assign w_evt  = wr_i && (addr_i == `DACR_OFS_EVENTS);
	assign w_ref  = wr_i && (addr_i == `DACR_OFS_REFCTL);

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			point_cnt_ff <= 16'h0000;
			interval_ff  <= 16'h0000;
		end else if (w_pace) begin
			point_cnt_ff <= wdata_i[31:16];
			interval_ff  <= wdata_i[15:0];
		end
	end

	// Pacing: fire when wait reaches interval + 2 ticks
	assign fire = tick && (wait_ff + 17'h1 >=
		{1'b0, interval_ff} + {1'b0, `DACR_TICK_ADD});
	assign under_ev = sample_o && fifo_empty_i;
	assign low_ev = (fifo_level_i == {2'b00, low_level_threshold_i})
		&& !low_prev_ff;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state_ff <= dacr_pkg::ST_IDLE;
			wait_ff  <= 17'h00000;
			left_ff  <= 32'h0;
			sample_o <= 1'b0;
			fin_ev   <= 1'b0;
		end else begin
			sample_o <= 1'b0;
			fin_ev   <= 1'b0;
			unique case (state_ff)
			dacr_pkg::ST_IDLE: begin
				wait_ff <= 17'h00000;
				left_ff <= total_points(point_cnt_ff, interp_i);
				// Every other cycle: the level lags a pop by one clock
				if (output_sequencing_select_i == dacr_pkg::MODE_FREE)
					sample_o <= !fifo_empty_i && !sample_o;
				else if (counted && !fifo_empty_i)
					state_ff <= dacr_pkg::ST_RUN;
			end
			dacr_pkg::ST_RUN: begin
				if (!counted) begin
					state_ff <= dacr_pkg::ST_IDLE;
				end else if (fire) begin
					wait_ff  <= 17'h00000;
					sample_o <= 1'b1;
					if (left_ff <= 32'h1) begin
						fin_ev   <= 1'b1;
						state_ff <= dacr_pkg::ST_DONE;
					end else begin
						left_ff <= left_ff - 32'h1;
					end
				end else if (tick) begin
					wait_ff <= wait_ff + 17'h1;
				end
			end
			dacr_pkg::ST_DONE: begin
				left_ff <= total_points(point_cnt_ff, interp_i);
				wait_ff <= 17'h00000;
				if (output_sequencing_select_i == dacr_pkg::MODE_REPEAT)
					state_ff <= dacr_pkg::ST_RUN;
				else if (!counted)
					state_ff <= dacr_pkg::ST_IDLE;
			end
			default: state_ff <= dacr_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i)
			low_prev_ff <= 1'b0;
		else
			low_prev_ff <= (fifo_level_i ==
				{2'b00, low_level_threshold_i});
	end

	// Masks and sticky flags: a set in the clearing cycle wins
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			stv_mask_ff <= 1'b0;
			fin_mask_ff <= 1'b0;
		end else if (w_evt) begin
			stv_mask_ff <= wdata_i[`DACR_BIT_STV_MASK];
			fin_mask_ff <= wdata_i[`DACR_BIT_FIN_MASK];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			stv_stat_ff <= 1'b0;
			low_flag_ff <= 1'b0;
			stv_flag_ff <= 1'b0;
			fin_flag_ff <= 1'b0;
		end else begin
			stv_stat_ff <= under_ev || (stv_stat_ff &&
				!(w_evt && wdata_i[`DACR_BIT_STV_STAT]));
			low_flag_ff <= low_ev || (low_flag_ff &&
				!(w_evt && wdata_i[`DACR_BIT_LOW_FLAG]));
			stv_flag_ff <= under_ev || (stv_flag_ff &&
				!(w_evt && wdata_i[`DACR_BIT_STV_FLAG]));
			fin_flag_ff <= fin_ev || (fin_flag_ff &&
				!(w_evt && wdata_i[`DACR_BIT_FIN_FLAG]));
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= (stv_flag_ff && stv_mask_ff)
				|| (fin_flag_ff && fin_mask_ff)
				|| low_flag_ff;
	end

	// Reference control, bits 5:0 writable, gain read-only
	always_ff @(posedge mclk_i) begin
		if (rst_i)
			ref_bits_ff <= 6'h00;
		else if (w_ref)
			ref_bits_ff <= wdata_i[5:0];
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ref_sel_o                  <= 2'b00;
			reference_power_up_o       <= 1'b0;
			ref_outen_o                <= 1'b0;
			reference_comp_pole_o      <= 1'b0;
			reference_quick_shutdown_o <= 1'b0;
		end else begin
			ref_sel_o <= ref_bits_ff[2:1];
			reference_power_up_o <= ref_bits_ff[`DACR_BIT_REFERENCE_POWER_UP];
			ref_outen_o <= ref_bits_ff[`DACR_BIT_REF_OUTEN];
			reference_comp_pole_o <= ref_bits_ff[`DACR_BIT_COMP_POLE];
			reference_quick_shutdown_o <=
				ref_bits_ff[`DACR_BIT_QUICK_PD];
		end
	end
	assign ref_sel_ff = ref_bits_ff[2:1];

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rdata_o <= `DACR_RST_WORD;
		end else if (rd_i) begin
			unique case (addr_i)
			`DACR_OFS_PACING: rdata_o <= {point_cnt_ff, interval_ff};
			`DACR_OFS_EVENTS: rdata_o <= {14'h0000, stv_mask_ff,
				fin_mask_ff, 12'h000, stv_stat_ff, low_flag_ff,
				stv_flag_ff, fin_flag_ff};
			`DACR_OFS_TRIM:   rdata_o <= {16'h0000, trim_i};
			`DACR_OFS_REFCTL: rdata_o <= {24'h000000, gain_i,
				ref_bits_ff[5:3], ref_sel_ff, ref_bits_ff[0]};
			default:          rdata_o <= 32'h0000_0000;
			endcase
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

	chk_stv_irq_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
		(stv_flag_ff && stv_mask_ff) |=> irq_o)
		else $error("starvation irq not raised");
	chk_fin_irq_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
		(!fin_flag_ff || !fin_mask_ff) && !low_flag_ff
		&& (!stv_flag_ff || !stv_mask_ff) |=> !irq_o)
		else $error("irq raised without cause");
	chk_stv_stat_set: assert property (@(posedge mclk_i)
		disable iff (rst_i) under_ev |=> stv_stat_ff)
		else $error("starvation status not set");
	chk_low_flag_set: assert property (@(posedge mclk_i)
		disable iff (rst_i) low_ev |=> low_flag_ff)
		else $error("low flag not set");
	chk_stv_flag_clr: assert property (@(posedge mclk_i)
		disable iff (rst_i) (w_evt && wdata_i[1] && !under_ev)
		|=> !stv_flag_ff)
		else $error("starvation flag not cleared");
	chk_fin_flag_hold: assert property (@(posedge mclk_i)
		disable iff (rst_i) (fin_flag_ff && !w_evt) |=> fin_flag_ff)
		else $error("finish flag dropped");
	chk_ref_power: assert property (@(posedge mclk_i) disable iff (rst_i)
		w_ref |=> ##1 (reference_power_up_o == $past(wdata_i[4], 2)))
		else $error("reference power not forwarded");
	chk_quick_pd: assert property (@(posedge mclk_i) disable iff (rst_i)
		w_ref |=> ##1 (reference_quick_shutdown_o ==
		$past(wdata_i[0], 2)))
		else $error("quick shutdown not forwarded");
	chk_pace_space: assert property (@(posedge mclk_i) disable iff (rst_i)
		(sample_o && state_ff == dacr_pkg::ST_RUN) |=>
		(!sample_o || !counted) [*8])
		else $error("samples too close");
endmodule

// [verif/dacr_far_model.sv]
// Far-side model: FIFO fill level and the reference level it sees.
// Assumes the bench loads the level while the block is idle.
`timescale 1ns/1ps
module dacr_far_model (
	input  wire logic       mclk_i,  // Clock
	input  wire logic       rst_i,   // Sync reset
	input  wire logic       pop_i,   // Sample taken
	input  wire logic       load_i,  // Load level
	input  wire logic [5:0] fill_i,  // Level to load
	input  wire logic [1:0] sel_i,   // Reference select
	input  wire logic       pu_i,    // Reference power
	input  wire logic       outen_i, // Internal output on
	output logic      [5:0] level_o, // FIFO level
	output logic            empty_o, // FIFO empty
	output int              mv_o     // Reference in mV
);
	always_ff @(posedge mclk_i) begin
		if (rst_i || load_i) begin
			level_o <= rst_i ? 6'h00 : fill_i;
		end else if (pop_i && level_o != 6'h00) begin
			level_o <= level_o - 6'h01;
		end
	end
	assign empty_o = (level_o == 6'h00);
	always_comb begin
		case (sel_i)
			2'h0: mv_o = 1024;
			2'h1: mv_o = 1500;
			2'h2: mv_o = 2048;
			default: mv_o = 2500;
		endcase
		if (!(pu_i && outen_i)) begin
			mv_o = 0;
		end
	end
endmodule

// [verif/tb_dacr_ctrl.sv]
// Self-checking bench for pacing, event flags and reference control.
// Assumes the far-side model supplies FIFO level and reference level.
`timescale 1ns/1ps
module tb_dacr_ctrl;
	localparam logic [15:0] TRIM = 16'hA5C3;
	localparam logic [1:0]  GAIN = 2'h2;
	localparam int          MV [4] = '{1024, 1500, 2048, 2500};
	logic        mclk_i  = 1'b0;
	logic        rst_i   = 1'b1;
	logic [3:0]  addr_i  = 4'h0;
	logic [31:0] wdata_i = 32'h0;
	logic        wr_i    = 1'b0;
	logic        rd_i    = 1'b0;
	logic [1:0]  mode    = 2'h0;
	logic [3:0]  interp  = 4'h0;
	logic        load    = 1'b0;
	logic [5:0]  fill    = 6'h00;
	logic [3:0]  thr     = 4'h4;
	logic [31:0] rdata_o;
	logic [5:0]  level;
	logic [1:0]  sel;
	logic        empty, sample, irq, pu, outen, cp, qpd;
	int          mv;
	int          err_count   = 0;
	int          checks_done = 0;
	always #20 mclk_i = ~mclk_i;
	dacr_ctrl i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.output_sequencing_select_i(mode), .interp_i(interp),
		.low_level_threshold_i(thr), .fifo_level_i(level),
		.fifo_empty_i(empty), .trim_i(TRIM), .gain_i(GAIN),
		.sample_o(sample), .irq_o(irq), .ref_sel_o(sel),
		.reference_power_up_o(pu), .ref_outen_o(outen),
		.reference_comp_pole_o(cp), .reference_quick_shutdown_o(qpd));
	dacr_far_model i_far (.mclk_i(mclk_i), .rst_i(rst_i), .pop_i(sample),
		.load_i(load), .fill_i(fill), .sel_i(sel), .pu_i(pu),
		.outen_i(outen), .level_o(level), .empty_o(empty), .mv_o(mv));
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [31:0] d);
		@(posedge mclk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		#1;
	endtask
	task automatic rc(logic [3:0] a, logic [31:0] e, logic [31:0] m,
		string what);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		chk(what, e, rdata_o & m);
	endtask
	task automatic t_reset;
		rc(4'h1, 32'h0, '1, "pacing");
		rc(4'h2, 32'h0, '1, "events");
		rc(4'h4, {16'h0, TRIM}, '1, "trim");
		rc(4'h5, {24'h0, GAIN, 6'h0}, '1, "refctl");
		rc(4'h3, 32'h0, '1, "unmapped");
	endtask
	task automatic t_ref;
		logic [31:0] w;
		for (int c = 0; c < 4; c++) begin
			w = 32'h0000_0039 | (c << 1);
			wr(4'h5, 32'hFFFF_FFC0 | w);
			chk("sel", c, sel);
			chk("mv", MV[c], mv);
			chk("ctl", 4'hF, {pu, outen, cp, qpd});
			rc(4'h5, w | {GAIN, 6'h0}, '1, "ref rb");
		end
		wr(4'h5, 32'h0);
		chk("off", 6'h00, {sel, pu, outen, cp, qpd});
	endtask
	task automatic t_free;
		@(posedge mclk_i);
		fill <= 6'h06;
		thr  <= 4'h2;
		load <= 1'b1;
		@(posedge mclk_i);
		load <= 1'b0;
		repeat (16) @(posedge mclk_i);
		chk("drained", 6'h00, level);
		rc(4'h2, 32'h4, 32'h4, "low flag");
		chk("irq low", 1, irq);
		wr(4'h2, 32'h0);
		rc(4'h2, 32'h4, 32'h4, "w0 keep");
		wr(4'h2, 32'hF);
		rc(4'h2, 32'h0, '1, "clr");
		chk("irq off", 0, irq);
		@(posedge mclk_i);
		thr <= 4'h4;
	endtask
	task automatic run(logic [1:0] m, logic [3:0] ip, bit gapchk,
		output int n);
		int gap;
		wr(4'h1, 32'h0003_0003);
		@(posedge mclk_i);
		interp <= ip;
		mode   <= m;
		fill   <= 6'h03;
		load   <= 1'b1;
		@(posedge mclk_i);
		load <= 1'b0;
		n   = 0;
		gap = 0;
		for (int t = 0; t < 700; t++) begin
			@(posedge mclk_i);
			#1;
			if (sample === 1'b1) begin
				n++;
				if (gapchk && n > 1) chk("gap", 1, gap >= 51 && gap <= 54);
				gap = 0;
			end
			gap++;
		end
		@(posedge mclk_i);
		mode <= 2'h0;
	endtask
	task automatic t_once;
		int n;
		run(2'h1, 4'h1, 1'b1, n);
		chk("points", 5, n);
		rc(4'h2, 32'hB, '1, "flags");
		chk("irq masked", 0, irq);
		wr(4'h2, 32'h0002_0000);
		chk("irq stv", 1, irq);
		wr(4'h2, 32'h0002_000A);
		rc(4'h2, 32'h0002_0001, '1, "stv clr");
		chk("irq fin off", 0, irq);
		wr(4'h2, 32'h0001_0000);
		chk("irq fin", 1, irq);
		wr(4'h2, 32'h0001_0001);
		rc(4'h2, 32'h0001_0000, '1, "fin clr");
		chk("irq none", 0, irq);
		wr(4'h2, 32'h0);
	endtask
	task automatic t_rep;
		int n;
		run(2'h3, 4'h0, 1'b1, n);
		chk("repeat", 1, n > 5);
		wr(4'h2, 32'hF);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		t_reset();
		t_ref();
		t_free();
		t_once();
		t_rep();
		final_report();
	end
	initial begin
		repeat (20000) @(posedge mclk_i);
		err_count++;
		final_report();
	end
endmodule
